// ==== rtl/urd_buf_mem.sv ====
// double input buffer storage: two blocks of bytes, one write port, one read port
// assumes the reader tolerates one cycle of read latency
module urd_buf_mem #(
  parameter int AW = 7
) (
  input  wire logic          clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [7:0]    rd_data_o
);

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : urd_buf_mem

// ==== rtl/urd_channel.sv ====
// uart receive dma channel with sof-clocked transaction time-out
// assumes an axi4-lite master, a uart fifo with valid/ready, a buffer manager that releases buffers
//
// Functional notes
// - five-bit time-out field, 0..31 ms
// - reload time-out counter on each byte
// - decrement counter on each sof pulse
// - at zero set time-out flag, halt
// - count only with enables and a byte
// - counter-enable bit off disables time-out
// - overrun flag hardware-set, write-one clears
// - time-out flag hardware-set, write-one clears
// - irq enable off keeps channel enabled
// - partial packet: time-out 1, overrun 0
// - both buffers full: both flags 1
// - uart error flags: prose taken, 1/0
// - full block: write count, mark ready
// - continuous alternate filling of both buffers
// - partial time-out flushes count and interrupts
// - both busy: time-out stops, both flags
// - uart error stops, enable stays set
// - interrupt on enable falling edge
//
// Implementation choice: the AXI4-Lite interface to the registers.
module urd_channel #(
  parameter int ADDR_W = urd_pkg::ADDR_W
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]          s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  input  wire logic [7:0]                 rx_data_i,
  input  wire logic                       rx_valid_i,
  output logic                            rx_ready_o,
  input  wire logic                       rx_error_i,
  input  wire logic                       sof_i,
  input  wire logic [1:0]                 bm_release_i,
  input  wire logic                       bm_toggle_i,
  input  wire logic [urd_pkg::MEM_AW-1:0] bm_rd_addr_i,
  output logic [7:0]                      bm_rd_data_o,
  output logic [1:0]                      buf_nak_o,
  output logic [urd_pkg::CNT_W-1:0]       buf_count_x_o,
  output logic [urd_pkg::CNT_W-1:0]       buf_count_y_o,
  output logic                            irq_o
);

  localparam int CW = urd_pkg::CNT_W;
  localparam int TW = urd_pkg::TO_W;

  urd_pkg::urd_state_t state;
  urd_pkg::urd_state_t next_state;

  // register fields
  logic          timeout_counter_enable;
  logic [TW-1:0] to_value;
  logic          tof;
  logic          ovf;
  logic          ch_en;
  logic          irq_en;
  logic          cont;
  logic          buf_sel;
  logic [2:0]    ep_ptr;

  // datapath state
  logic          en_d;
  logic          got_byte;
  logic [TW-1:0] timer;
  logic          fill_sel;
  logic [CW-1:0] fill_cnt;

  // axi capture
  logic              aw_got;
  logic              w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;

  logic          next_en;
  logic          next_got;
  logic [TW-1:0] next_timer;
  logic          next_fill_sel;
  logic [CW-1:0] next_fill_cnt;
  logic [1:0]    next_nak;
  logic          next_tof;
  logic          next_ovf;

  // bus decode
  wire wr_fire  = aw_got && w_got && !s_axi_bvalid_o;
  wire wr_ctrl  = wr_fire && w_lane0 && urd_pkg::urd_hit(aw_addr, urd_pkg::CTRL_IDX);
  wire wr_stat  = wr_fire && w_lane0 && urd_pkg::urd_hit(aw_addr, urd_pkg::STAT_IDX);
  wire wr_map   = urd_pkg::urd_hit(aw_addr, urd_pkg::CTRL_IDX) || urd_pkg::urd_hit(aw_addr, urd_pkg::STAT_IDX);
  wire rd_fire  = s_axi_arvalid_i && s_axi_arready_o;
  wire rd_ctrl  = urd_pkg::urd_hit(s_axi_araddr_i, urd_pkg::CTRL_IDX);
  wire rd_stat  = urd_pkg::urd_hit(s_axi_araddr_i, urd_pkg::STAT_IDX);
  wire sw_start = wr_ctrl && w_byte[urd_pkg::CT_EN];
  wire sw_stop  = wr_ctrl && !w_byte[urd_pkg::CT_EN];

  wire [7:0] stat_byte = {timeout_counter_enable, to_value, tof, ovf};
  wire [7:0] ctrl_byte = {ch_en, irq_en, cont, buf_sel, 1'b1, ep_ptr};

  // channel events
  wire accept    = rx_valid_i && rx_ready_o;
  wire timer_run = timeout_counter_enable && ch_en && got_byte && (state == urd_pkg::URD_RUN);
  wire tick      = sof_i && timer_run;
  wire expire    = tick && !accept && (timer <= urd_pkg::TO_LAST);
  wire uart_err  = rx_error_i && (state == urd_pkg::URD_RUN);
  wire both_full = !buf_nak_o[0] && !buf_nak_o[1];
  wire [CW-1:0] cnt_after = accept ? fill_cnt + urd_pkg::CNT_ONE : fill_cnt;
  wire block_done = accept && (fill_cnt == urd_pkg::CNT_LAST);
  wire flush      = (expire || uart_err) && (cnt_after != urd_pkg::CNT_ZERO);
  wire close_buf  = block_done || flush;
  wire [CW-1:0] close_count = block_done ? urd_pkg::CNT_FULL : cnt_after;

  // buffers alternate with no software action; a closed buffer waits for its release
  always_comb begin
    next_nak = buf_nak_o | bm_release_i;
    if (close_buf) begin
      next_nak[fill_sel] = 1'b0;
    end
    next_fill_sel = close_buf ? !fill_sel : fill_sel;
    next_fill_cnt = close_buf ? urd_pkg::CNT_ZERO : cnt_after;
  end

  always_comb begin
    next_state = state;
    next_en    = ch_en;
    next_got   = accept ? 1'b1 : got_byte;
    case (state)
      urd_pkg::URD_IDLE: begin
        if (sw_start) begin
          next_state = urd_pkg::URD_RUN;
          next_en    = 1'b1;
          next_got   = 1'b0;
        end
      end
      urd_pkg::URD_RUN: begin
        if (sw_stop) begin
          next_state = urd_pkg::URD_IDLE;
          next_en    = 1'b0;
        end else if (uart_err) begin
          next_state = urd_pkg::URD_STOPPED;
        end else if (expire && irq_en) begin
          next_state = urd_pkg::URD_IDLE;
          next_en    = 1'b0;
        end else if (expire) begin
          next_got   = 1'b0;
        end
      end
      urd_pkg::URD_STOPPED: begin
        if (sw_stop) begin
          next_state = urd_pkg::URD_IDLE;
          next_en    = 1'b0;
        end else if (sw_start) begin
          next_state = urd_pkg::URD_RUN;
          next_got   = 1'b0;
        end
      end
      default: begin
        next_state = urd_pkg::URD_IDLE;
        next_en    = 1'b0;
      end
    endcase
  end

  // timer reload wins over the sof tick, so a byte on the tick edge restarts the full window
  always_comb begin
    next_timer = timer;
    if (accept) begin
      next_timer = to_value;
    end else if (tick && !expire) begin
      next_timer = timer - urd_pkg::TO_LAST;
    end
  end

  // hardware set wins over a write-one clear in the same cycle
  always_comb begin
    next_tof = tof;
    next_ovf = ovf;
    if (wr_stat && w_byte[urd_pkg::ST_TOF]) begin
      next_tof = 1'b0;
    end
    if (wr_stat && w_byte[urd_pkg::ST_OVF]) begin
      next_ovf = 1'b0;
    end
    if (expire || uart_err) begin
      next_tof = 1'b1;
      next_ovf = expire && both_full;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state    <= urd_pkg::URD_IDLE;
      ch_en    <= 1'b0;
      en_d     <= 1'b0;
      got_byte <= 1'b0;
      timer    <= urd_pkg::TO_RST;
      fill_sel <= 1'b0;
      fill_cnt <= urd_pkg::CNT_ZERO;
      tof      <= 1'b0;
      ovf      <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      state    <= next_state;
      ch_en    <= next_en;
      en_d     <= ch_en;
      got_byte <= next_got;
      timer    <= next_timer;
      fill_sel <= next_fill_sel;
      fill_cnt <= next_fill_cnt;
      tof      <= next_tof;
      ovf      <= next_ovf;
      irq_o    <= irq_en && en_d && !ch_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      buf_nak_o     <= urd_pkg::NAK_RST;
      buf_count_x_o <= urd_pkg::CNT_ZERO;
      buf_count_y_o <= urd_pkg::CNT_ZERO;
      rx_ready_o    <= 1'b0;
    end else begin
      buf_nak_o  <= next_nak;
      rx_ready_o <= (next_state == urd_pkg::URD_RUN) && next_nak[next_fill_sel];
      if (close_buf && !fill_sel) begin
        buf_count_x_o <= close_count;
      end
      if (close_buf && fill_sel) begin
        buf_count_y_o <= close_count;
      end
    end
  end

  // software fields; the select bit follows the buffer manager or a write with bit 3 low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timeout_counter_enable      <= 1'b0;
      to_value <= urd_pkg::TO_RST;
      irq_en   <= 1'b0;
      cont     <= 1'b0;
      buf_sel  <= 1'b0;
      ep_ptr   <= urd_pkg::EP_RST;
    end else begin
      if (wr_stat) begin
        timeout_counter_enable      <= w_byte[urd_pkg::ST_TEN];
        to_value <= w_byte[urd_pkg::ST_TO_HI:urd_pkg::ST_TO_LO];
      end
      if (wr_ctrl) begin
        irq_en <= w_byte[urd_pkg::CT_IRQ];
        cont   <= w_byte[urd_pkg::CT_CONT];
        ep_ptr <= w_byte[urd_pkg::CT_EP_HI:0];
      end
      if (bm_toggle_i) begin
        buf_sel <= !buf_sel;
      end else if (wr_ctrl && !w_byte[urd_pkg::CT_TR]) begin
        buf_sel <= w_byte[urd_pkg::CT_SEL];
      end
    end
  end

  // axi4-lite write: address and data taken in either order, one write at a time
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      aw_addr         <= '0;
      w_byte          <= 8'h00;
      w_lane0         <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= urd_pkg::RESP_OKAY;
    end else begin
      s_axi_awready_o <= !aw_got && !(s_axi_awvalid_i && s_axi_awready_o) && !s_axi_bvalid_o;
      s_axi_wready_o  <= !w_got && !(s_axi_wvalid_i && s_axi_wready_o) && !s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got   <= 1'b1;
        w_byte  <= s_axi_wdata_i[7:0];
        w_lane0 <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        aw_got         <= 1'b0;
        w_got          <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_map ? urd_pkg::RESP_OKAY : urd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // axi4-lite read: one read at a time, answer the cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= urd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= {24'h00_0000, rd_ctrl ? ctrl_byte : (rd_stat ? stat_byte : 8'h00)};
        s_axi_rresp_o  <= (rd_ctrl || rd_stat) ? urd_pkg::RESP_OKAY : urd_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  urd_buf_mem #(
    .AW (urd_pkg::MEM_AW)
  ) u_buf_mem (
    .clk_i     (clk_i),
    .wr_en_i   (accept),
    .wr_addr_i ({fill_sel, fill_cnt[CW-2:0]}),
    .wr_data_i (rx_data_i),
    .rd_addr_i (bm_rd_addr_i),
    .rd_data_o (bm_rd_data_o)
  );

endmodule : urd_channel

// ==== rtl/urd_pkg.sv ====
// constants, register layout and types of the uart receive dma channel
// assumes a 32-bit axi4-lite register bus with one byte register per aligned word
package urd_pkg;

  localparam int          ADDR_W       = 18;
  localparam int          DATA_W       = 32;
  localparam int          BLOCK_BYTES  = 64;
  localparam int          CNT_W        = 7;
  localparam int          TO_W         = 5;
  localparam int          MEM_AW       = 7;

  // register indices; the byte address is four times the index
  localparam logic [15:0] CTRL_IDX     = 16'hffe4;
  localparam logic [15:0] STAT_IDX     = 16'hffe5;

  // status register fields
  localparam int          ST_TEN       = 7;
  localparam int          ST_TO_HI     = 6;
  localparam int          ST_TO_LO     = 2;
  localparam int          ST_TOF       = 1;
  localparam int          ST_OVF       = 0;

  // control register fields
  localparam int          CT_EN        = 7;
  localparam int          CT_IRQ       = 6;
  localparam int          CT_CONT      = 5;
  localparam int          CT_SEL       = 4;
  localparam int          CT_TR        = 3;
  localparam int          CT_EP_HI     = 2;

  localparam logic [TO_W-1:0]  TO_RST     = 5'h00;
  localparam logic [TO_W-1:0]  TO_LAST    = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 7'h01;
  localparam logic [CNT_W-1:0] CNT_FULL   = 7'h40;
  localparam logic [CNT_W-1:0] CNT_LAST   = 7'h3f;
  localparam logic [2:0]       EP_RST     = 3'h0;
  localparam logic [1:0]       NAK_RST    = 2'h3;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    URD_IDLE,
    URD_RUN,
    URD_STOPPED
  } urd_state_t;

  function automatic logic urd_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    urd_hit = (addr[ADDR_W-1:2] == idx);
  endfunction : urd_hit

endpackage : urd_pkg

// ==== testbench/urd_bm_model.sv ====
// buffer manager model: drains each buffer handed to the host, then frees it
// assumes the channel closes buffers alternately; hold_i stalls it like a busy host
module urd_bm_model (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       hold_i,
  input  wire logic [7:0]                 delay_i,
  input  wire logic [1:0]                 buf_nak_i,
  input  wire logic [urd_pkg::CNT_W-1:0]  count_x_i,
  input  wire logic [urd_pkg::CNT_W-1:0]  count_y_i,
  input  wire logic [7:0]                 rd_data_i,
  output logic      [1:0]                 release_o,
  output logic                            toggle_o,
  output logic      [urd_pkg::MEM_AW-1:0] rd_addr_o,
  output logic      [7:0]                 got_o,
  output logic                            got_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel;
  int   cnt;
  initial begin
    {release_o, toggle_o, rd_addr_o, got_o, got_valid_o} = '0;
    sel = 1'b0;
    forever begin
      @(posedge clk_i);
      if (reset_i)
        sel = 1'b0;
      else if (!hold_i && buf_nak_i != 2'b11) begin
        if (buf_nak_i[sel])
          sel = ~sel;
        cnt = sel ? int'(count_y_i) : int'(count_x_i);
        repeat (delay_i) @(posedge clk_i);
        // registered read data trails the address by two edges as seen here
        for (int i = 0; i <= cnt + 1; i++) begin
          rd_addr_o   <= {sel, 6'(i)};
          got_o       <= rd_data_i;
          got_valid_o <= (i >= 2);
          @(posedge clk_i);
        end
        got_valid_o    <= 1'b0;
        release_o[sel] <= 1'b1;
        toggle_o       <= 1'b1;
        @(posedge clk_i);
        release_o <= 2'b00;
        toggle_o  <= 1'b0;
        sel = ~sel;
      end
    end
  end
endmodule : urd_bm_model

// ==== testbench/urd_channel_tb_top.sv ====
// bench of the receive dma channel: register rows, then hand-written cases
// assumes the buffer manager model on the far side; sof pulses come a few cycles apart
module urd_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] SA = {urd_pkg::STAT_IDX, 2'b00};
  localparam logic [17:0] CA = {urd_pkg::CTRL_IDX, 2'b00};
  localparam logic [1:0]  OK = urd_pkg::RESP_OKAY;
  typedef struct packed {logic [17:0] a; logic [7:0] w; logic [7:0] e; logic [1:0] rs;} urd_row_t;
  logic        clk_i = 1'b0, reset_i = 1'b1;
  logic [17:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, d;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, awr, wr, bv, arr, rv;
  logic [1:0]  br, rr, rel, nak, r;
  logic [7:0]  rx_d = '0, mem_d, got, seq = 8'h01, bm_delay = '0;
  logic        rx_v = 1'b0, rx_r, rx_err = 1'b0, sof = 1'b0, tog, irq, hold = 1'b0, got_v;
  logic [6:0]  mem_a, cx, cy;
  logic [7:0]  exp_q[$];
  int          num_errors = 0, check_count = 0, irq_cnt = 0, cycles = 0;
  urd_row_t    rows[7] = '{
    '{SA, 8'hfc, 8'hfc, OK},
    '{SA, 8'h03, 8'h00, OK},
    '{CA, 8'h27, 8'h2f, OK},
    '{CA, 8'h10, 8'h18, OK},
    '{CA, 8'h08, 8'h18, OK},
    '{18'h00100, 8'h55, 8'h00, urd_pkg::RESP_SLVERR},
    '{CA, 8'h00, 8'h08, OK}};

  urd_channel i_urd_channel (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .rx_data_i(rx_d), .rx_valid_i(rx_v), .rx_ready_o(rx_r), .rx_error_i(rx_err), .sof_i(sof),
    .bm_release_i(rel), .bm_toggle_i(tog), .bm_rd_addr_i(mem_a), .bm_rd_data_o(mem_d), .buf_nak_o(nak),
    .buf_count_x_o(cx), .buf_count_y_o(cy), .irq_o(irq));
  urd_bm_model i_urd_bm_model (
    .clk_i(clk_i), .reset_i(reset_i), .hold_i(hold), .delay_i(bm_delay), .buf_nak_i(nak), .count_x_i(cx),
    .count_y_i(cy), .rd_data_i(mem_d), .release_o(rel), .toggle_o(tog), .rd_addr_o(mem_a), .got_o(got),
    .got_valid_o(got_v));

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s, got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic do_reset;
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task automatic axi_wr(input logic [17:0] a, input logic [7:0] v);
    awa <= a;
    wd  <= {24'h0, v};
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
    bre <= 1'b0;
    @(posedge clk_i);
  endtask : axi_wr

  task automatic rchk(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    r = rr;
    rre <= 1'b0;
    @(posedge clk_i);
    chk(d & {24'h0, m}, {24'h0, e}, s);
  endtask : rchk

  task automatic send(input int n);
    repeat (n) begin
      rx_d <= seq;
      rx_v <= 1'b1;
      seq = seq + 8'h01;
      do @(posedge clk_i); while (rx_r !== 1'b1);
    end
    rx_v <= 1'b0;
    rx_d <= ~rx_d;
  endtask : send

  task automatic pulse_sof(input int n);
    repeat (n) begin
      sof <= 1'b1;
      @(posedge clk_i);
      sof <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulse_sof

  always #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles++;
    if (irq === 1'b1) irq_cnt++;
    if (rx_v && rx_r === 1'b1) exp_q.push_back(rx_d);
    if (got_v === 1'b1) begin
      chk(32'(got), 32'(exp_q.size() > 0 ? exp_q[0] : ~got), "byte order to host");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
    // generous ceiling: the whole run needs well under a thousand cycles
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    foreach (rows[k]) begin
      axi_wr(rows[k].a, rows[k].w);
      chk(32'(r), 32'(rows[k].rs), "write response");
      rchk(rows[k].a, 8'hff, rows[k].e, "register read back");
      chk(32'(r), 32'(rows[k].rs), "read response");
    end
    $display("end of register rows");
    do_reset();
    rchk(SA, 8'hff, 8'h00, "status after reset");
    rchk(CA, 8'hff, 8'h08, "control after reset");
    chk(32'(nak), 32'h3, "buffers free after reset");
    $display("end of reset test");
    axi_wr(SA, 8'h8c);
    axi_wr(CA, 8'hc0);
    send(130);
    pulse_sof(2);
    send(1);
    pulse_sof(2);
    rchk(SA, 8'hff, 8'h8c, "byte reloads the count");
    pulse_sof(1);
    rchk(SA, 8'hff, 8'h8e, "partial packet code");
    chk(32'(cx), 32'h3, "partial count");
    chk(32'(irq_cnt), 32'h1, "irq on time-out");
    rchk(CA, 8'hef, 8'h48, "enable cleared");
    axi_wr(SA, 8'h8c);
    rchk(SA, 8'hff, 8'h8e, "write of zero keeps flag");
    axi_wr(SA, 8'h8e);
    rchk(SA, 8'hff, 8'h8c, "write of one clears flag");
    $display("end of time-out test");
    // the partial buffer must reach the host first, or the 128 bytes below cannot all land
    for (int n = 0; n < 400 && nak !== 2'b11; n++) @(posedge clk_i);
    chk(32'(nak), 32'h3, "partial buffer drained");
    hold <= 1'b1;
    axi_wr(CA, 8'h80);
    send(128);
    pulse_sof(3);
    rchk(SA, 8'hff, 8'h8f, "overrun code");
    rchk(CA, 8'h80, 8'h80, "enable kept with irq off");
    chk(32'(irq_cnt), 32'h1, "no irq with irq off");
    axi_wr(SA, 8'h8f);
    rchk(SA, 8'hff, 8'h8c, "both flags cleared");
    hold <= 1'b0;
    for (int n = 0; n < 400 && nak !== 2'b11; n++) @(posedge clk_i);
    chk(32'(nak), 32'h3, "buffers drained");
    $display("end of overrun test");
    bm_delay <= 8'd20;
    send(5);
    rx_err <= 1'b1;
    @(posedge clk_i);
    rx_err <= 1'b0;
    rchk(SA, 8'hff, 8'h8e, "uart error code");
    rchk(CA, 8'h80, 8'h80, "enable kept after uart error");
    chk(32'(rx_r), 32'h0, "channel stopped");
    chk(32'(irq_cnt), 32'h1, "no irq on uart error");
    $display("end of uart error test");
    axi_wr(SA, 8'h0e);
    axi_wr(CA, 8'hc0);
    send(1);
    pulse_sof(5);
    rchk(SA, 8'hff, 8'h0c, "no time-out with counter off");
    axi_wr(CA, 8'h40);
    for (int n = 0; n < 10 && irq_cnt < 2; n++) @(posedge clk_i);
    chk(32'(irq_cnt), 32'h2, "irq on software stop");
    $display("end of counter-off test");
    report_and_stop();
  end
endmodule : urd_channel_tb_top

// ==== testbench/urd_chk.sv ====
// port checker of the receive dma channel, bound into every instance
// assumes one clock domain and the synchronous reset of the channel
module urd_chk (
  input wire logic                      clk_i,
  input wire logic                      reset_i,
  input wire logic                      rx_ready_o,
  input wire logic                      rx_error_i,
  input wire logic [1:0]                bm_release_i,
  input wire logic [1:0]                buf_nak_o,
  input wire logic [urd_pkg::CNT_W-1:0] buf_count_x_o,
  input wire logic [urd_pkg::CNT_W-1:0] buf_count_y_o,
  input wire logic                      irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_irq_one_cycle: assert property (irq_o |=> !irq_o)
    else $error("irq pulse longer than one cycle");
  a_err_no_irq: assert property (rx_error_i && rx_ready_o |=> (!irq_o) [*4])
    else $error("irq raised by a uart error");
  a_err_stops: assert property (rx_error_i && rx_ready_o |-> ##[1:3] !rx_ready_o)
    else $error("bytes still taken after a uart error");
  a_ready_free: assert property (rx_ready_o |-> buf_nak_o != 2'b00)
    else $error("bytes taken while both buffers wait for the host");
  a_x_count: assert property ($fell(buf_nak_o[0]) |-> buf_count_x_o inside {[7'h01:7'h40]})
    else $error("x buffer closed with a bad count");
  a_y_count: assert property ($fell(buf_nak_o[1]) |-> buf_count_y_o inside {[7'h01:7'h40]})
    else $error("y buffer closed with a bad count");
  a_x_held: assert property (!buf_nak_o[0] && !bm_release_i[0] |=> !buf_nak_o[0])
    else $error("x buffer reclaimed before the host took it");
  a_y_stable: assert property (!buf_nak_o[1] |=> $stable(buf_count_y_o))
    else $error("y count changed while waiting for the host");

  c_irq: cover property (irq_o);
  c_overrun: cover property (buf_nak_o == 2'b00);
  c_err: cover property (rx_error_i && rx_ready_o);
endmodule : urd_chk

bind urd_channel urd_chk i_urd_chk (
  .clk_i(clk_i), .reset_i(reset_i), .rx_ready_o(rx_ready_o), .rx_error_i(rx_error_i), .bm_release_i(bm_release_i),
  .buf_nak_o(buf_nak_o), .buf_count_x_o(buf_count_x_o), .buf_count_y_o(buf_count_y_o), .irq_o(irq_o)
);
